// ---- isr_pkg.sv ----
// Purpose: shared constants and carriers for the status reporting block
// Assumes: one system clock, asynchronous active-low power-on reset
// Notes:   bit positions follow the status byte and standard event layouts
package isr_pkg;

    // ************************************************************
    // status byte bit positions
    // ************************************************************
    localparam int STB_QUEUE_BIT = 2;
    localparam int STB_QUES_BIT  = 3;
    localparam int STB_MAV_BIT   = 4;
    localparam int STB_ESB_BIT   = 5;
    localparam int STB_RQS_BIT   = 6;
    localparam int STB_OPER_BIT  = 7;

    // ************************************************************
    // standard event bit positions
    // ************************************************************
    localparam int SEV_OPC_BIT = 0;
    localparam int SEV_QYE_BIT = 2;
    localparam int SEV_DDE_BIT = 3;
    localparam int SEV_EXE_BIT = 4;
    localparam int SEV_CME_BIT = 5;
    localparam int SEV_PON_BIT = 7;

    // ************************************************************
    // widths and reset / preset values
    // ************************************************************
    localparam int SCPI_W = 16;
    localparam logic [SCPI_W-1:0] ENAB_RESET = 16'h0000;
    localparam logic [SCPI_W-1:0] PTR_RESET  = 16'h7FFF;
    localparam logic [SCPI_W-1:0] NTR_RESET  = 16'h0000;
    localparam logic [7:0]        BYTE_ZERO  = 8'h00;
    localparam logic [7:0]        PON_RESET  = 8'h80;

    // ************************************************************
    // register selectors for the command port
    // ************************************************************
    typedef enum logic [2:0] {
        ISR_SEL_OPER,
        ISR_SEL_QUES,
        ISR_SEL_STD,
        ISR_SEL_SRE,
        ISR_SEL_NONE
    } isr_sel_e;

    typedef enum logic [1:0] {
        ISR_FLD_ENAB,
        ISR_FLD_PTR,
        ISR_FLD_NTR
    } isr_fld_e;

    // one write from the command parser
    typedef struct packed {
        logic              valid;
        isr_sel_e          sel;
        isr_fld_e          fld;
        logic [SCPI_W-1:0] data;
    } isr_wr_s;

    // one-cycle standard event pulses from the parser
    typedef struct packed {
        logic opc_done;
        logic query_err;
        logic dev_err;
        logic exec_err;
        logic cmd_err;
    } isr_sev_s;

endpackage : isr_pkg

// ---- isr_scpi_reg.sv ----
// Purpose: one SCPI status register: condition, filters, event, enable
// Assumes: condition inputs already synchronised to i_clk
// Notes:   event read clears, new transitions in the same cycle survive
`timescale 1ns/100ps
`default_nettype none
module isr_scpi_reg #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // live condition
    input  wire logic [W-1:0] i_cond,
    // configuration writes
    input  wire logic         i_wr_enab,
    input  wire logic         i_wr_ptr,
    input  wire logic         i_wr_ntr,
    input  wire logic         i_preset,
    input  wire logic [W-1:0] i_wdata,
    // read of event clears it
    input  wire logic         i_rd_event,
    // status
    output logic [W-1:0]      o_cond,
    output logic [W-1:0]      o_event,
    output logic [W-1:0]      o_enab,
    output logic [W-1:0]      o_ptr,
    output logic [W-1:0]      o_ntr,
    output logic              o_summary
);

    logic [W-1:0] cond_q;
    logic [W-1:0] event_q;
    logic [W-1:0] event_d;
    logic [W-1:0] enab_q;
    logic [W-1:0] ptr_q;
    logic [W-1:0] ntr_q;
    logic [W-1:0] hit;

    // ************************************************************
    // per-bit transition filter
    // ************************************************************
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            // rising edge reported through ptr, falling through ntr
            assign hit[b] = (ptr_q[b] & ~cond_q[b] & i_cond[b])
                          | (ntr_q[b] & cond_q[b] & ~i_cond[b]);
        end
    endgenerate

    // set wins over read-clear
    assign event_d = (i_rd_event ? '0 : event_q) | hit;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cond_q  <= '0;
            event_q <= '0;
        end else begin
            cond_q  <= i_cond;
            event_q <= event_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enab_q <= W'(isr_pkg::ENAB_RESET);
            ptr_q  <= W'(isr_pkg::PTR_RESET);
            ntr_q  <= W'(isr_pkg::NTR_RESET);
        end else if (i_preset) begin
            enab_q <= W'(isr_pkg::ENAB_RESET);
            ptr_q  <= W'(isr_pkg::PTR_RESET);
            ntr_q  <= W'(isr_pkg::NTR_RESET);
        end else begin
            if (i_wr_enab) enab_q <= i_wdata;
            if (i_wr_ptr)  ptr_q  <= i_wdata;
            if (i_wr_ntr)  ntr_q  <= i_wdata;
        end
    end

    assign o_cond    = cond_q;
    assign o_event   = event_q;
    assign o_enab    = enab_q;
    assign o_ptr     = ptr_q;
    assign o_ntr     = ntr_q;
    assign o_summary = |(event_q & enab_q);

endmodule : isr_scpi_reg
`default_nettype wire

// ---- isr_status_top.sv ----
// Purpose: status byte, standard event register and service request logic
// Assumes: parser pulses and writes come from logic on i_clk
// Notes:   condition inputs from the instrument are synchronised here
`timescale 1ns/100ps
`default_nettype none
// Operation
// - positive filter set: latch event when condition rises
// - negative filter set: latch event when condition falls
// - both filters set: latch event on every condition change
// - both filters clear: never latch an event for that bit
// - status byte readable by serial poll and by status-byte query
// - serial poll returns request-service in bit 6, byte unchanged
// - status query returns master summary in bit 6, changes nothing
// - status byte bits 0 and 1 always read zero
// - bit 2 true while error/event queue not empty
// - bit 3 set when enabled questionable event present
// - bit 4 set when query response data is ready
// - bit 5 summarises standard event register
// - master summary when any enabled status byte bit is set
// - service request line active while request-service true
// - bit 7 set when enabled operation event present
// - standard event register reached by enable write, enable and event queries
// - event bit 0 on operation complete after pending operations finish
// - event bit 2 on query error
// - event bit 3 on device-specific error
// - event bit 4 on execution error
// - event bit 5 on command error or trigger in input buffer
// - event bit 7 set at power-up
// - reading event register clears it; condition read is live
// - summary only from event bits with enable set
module isr_status_top #(
    parameter int W = isr_pkg::SCPI_W
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // instrument conditions, asynchronous
    input  wire logic [W-1:0]         i_oper_cond,
    input  wire logic [W-1:0]         i_ques_cond,
    // parser side
    input  wire isr_pkg::isr_wr_s     i_wr,
    input  wire logic                 i_preset,
    input  wire logic                 i_clear_status,
    input  wire isr_pkg::isr_sev_s    i_sev,
    input  wire logic                 i_trg_in_buffer,
    input  wire logic                 i_queue_nonempty,
    input  wire logic                 i_msg_ready,
    // reads, one-cycle strobes
    input  wire logic                 i_rd_oper_event,
    input  wire logic                 i_rd_ques_event,
    input  wire logic                 i_rd_std_event,
    input  wire logic                 i_serial_poll,
    input  wire logic                 i_stb_query,
    // read data
    output logic [W-1:0]              o_oper_event,
    output logic [W-1:0]              o_oper_cond,
    output logic [W-1:0]              o_ques_event,
    output logic [W-1:0]              o_ques_cond,
    output logic [W-1:0]              o_oper_enab,
    output logic [W-1:0]              o_ques_enab,
    output logic [W-1:0]              o_oper_ptr,
    output logic [W-1:0]              o_oper_ntr,
    output logic [W-1:0]              o_ques_ptr,
    output logic [W-1:0]              o_ques_ntr,
    output logic [15:0]               o_std_event,
    output logic [15:0]               o_std_enab,
    output logic [15:0]               o_sre,
    output logic [15:0]               o_stb_resp,
    output logic                      o_stb_resp_valid,
    // gpib service request line
    output logic                      o_srq
);

    // ************************************************************
    // condition synchronisers
    // ************************************************************
    logic [W-1:0] oper_meta_q;
    logic [W-1:0] oper_sync_q;
    logic [W-1:0] ques_meta_q;
    logic [W-1:0] ques_sync_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oper_meta_q <= '0;
            oper_sync_q <= '0;
            ques_meta_q <= '0;
            ques_sync_q <= '0;
        end else begin
            oper_meta_q <= i_oper_cond;
            oper_sync_q <= oper_meta_q;
            ques_meta_q <= i_ques_cond;
            ques_sync_q <= ques_meta_q;
        end
    end

    // ************************************************************
    // write decode
    // ************************************************************
    wire wr_oper = i_wr.valid && (i_wr.sel == isr_pkg::ISR_SEL_OPER);
    wire wr_ques = i_wr.valid && (i_wr.sel == isr_pkg::ISR_SEL_QUES);
    wire wr_std  = i_wr.valid && (i_wr.sel == isr_pkg::ISR_SEL_STD)
                 && (i_wr.fld == isr_pkg::ISR_FLD_ENAB);
    wire wr_sre  = i_wr.valid && (i_wr.sel == isr_pkg::ISR_SEL_SRE);
    wire fld_en  = (i_wr.fld == isr_pkg::ISR_FLD_ENAB);
    wire fld_pt  = (i_wr.fld == isr_pkg::ISR_FLD_PTR);
    wire fld_nt  = (i_wr.fld == isr_pkg::ISR_FLD_NTR);
    // clear status empties event registers like a read
    wire clr_oper = i_rd_oper_event | i_clear_status;
    wire clr_ques = i_rd_ques_event | i_clear_status;

    // ************************************************************
    // scpi registers
    // ************************************************************
    logic oper_sum;
    logic ques_sum;

    isr_scpi_reg #(.W(W)) u_oper (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_cond     (oper_sync_q),
        .i_wr_enab  (wr_oper & fld_en),
        .i_wr_ptr   (wr_oper & fld_pt),
        .i_wr_ntr   (wr_oper & fld_nt),
        .i_preset   (i_preset),
        .i_wdata    (i_wr.data),
        .i_rd_event (clr_oper),
        .o_cond     (o_oper_cond),
        .o_event    (o_oper_event),
        .o_enab     (o_oper_enab),
        .o_ptr      (o_oper_ptr),
        .o_ntr      (o_oper_ntr),
        .o_summary  (oper_sum)
    );

    isr_scpi_reg #(.W(W)) u_ques (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_cond     (ques_sync_q),
        .i_wr_enab  (wr_ques & fld_en),
        .i_wr_ptr   (wr_ques & fld_pt),
        .i_wr_ntr   (wr_ques & fld_nt),
        .i_preset   (i_preset),
        .i_wdata    (i_wr.data),
        .i_rd_event (clr_ques),
        .o_cond     (o_ques_cond),
        .o_event    (o_ques_event),
        .o_enab     (o_ques_enab),
        .o_ptr      (o_ques_ptr),
        .o_ntr      (o_ques_ntr),
        .o_summary  (ques_sum)
    );

    // ************************************************************
    // standard event status register
    // ************************************************************
    logic [7:0] std_event_q;
    logic [7:0] std_enab_q;
    logic [7:0] sre_q;
    logic [7:0] std_set;
    logic [7:0] std_event_d;

    always_comb begin
        std_set                        = isr_pkg::BYTE_ZERO;
        std_set[isr_pkg::SEV_OPC_BIT]  = i_sev.opc_done;
        std_set[isr_pkg::SEV_QYE_BIT]  = i_sev.query_err;
        std_set[isr_pkg::SEV_DDE_BIT]  = i_sev.dev_err;
        std_set[isr_pkg::SEV_EXE_BIT]  = i_sev.exec_err;
        std_set[isr_pkg::SEV_CME_BIT]  = i_sev.cmd_err | i_trg_in_buffer;
    end

    // event query clears; a new event in the same cycle wins
    assign std_event_d = ((i_rd_std_event | i_clear_status) ? isr_pkg::BYTE_ZERO
                         : std_event_q) | std_set;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            std_event_q <= isr_pkg::PON_RESET;
        end else begin
            std_event_q <= std_event_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            std_enab_q <= isr_pkg::BYTE_ZERO;
            sre_q      <= isr_pkg::BYTE_ZERO;
        end else begin
            if (wr_std) std_enab_q <= i_wr.data[7:0];
            if (wr_sre) sre_q      <= i_wr.data[7:0];
        end
    end

    // ************************************************************
    // status byte and service request
    // ************************************************************
    logic [7:0] stb_base;
    logic       mss;
    logic       esb;

    assign esb = |(std_event_q & std_enab_q);

    always_comb begin
        stb_base                         = isr_pkg::BYTE_ZERO;
        stb_base[isr_pkg::STB_QUEUE_BIT] = i_queue_nonempty;
        stb_base[isr_pkg::STB_QUES_BIT]  = ques_sum;
        stb_base[isr_pkg::STB_MAV_BIT]   = i_msg_ready;
        stb_base[isr_pkg::STB_ESB_BIT]   = esb;
        stb_base[isr_pkg::STB_OPER_BIT]  = oper_sum;
    end

    // bit 6 position of the enable mask is masked off
    wire [7:0] sre_eff = sre_q & ~(8'h01 << isr_pkg::STB_RQS_BIT);
    assign mss = |(stb_base & sre_eff);

    // request service follows the master summary; polling never clears it
    logic       rqs_q;
    logic [7:0] resp_q;
    logic       resp_vld_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rqs_q <= 1'b0;
        end else begin
            rqs_q <= mss;
        end
    end

    wire [7:0] poll_byte  = stb_base | ({7'h00, rqs_q} << isr_pkg::STB_RQS_BIT);
    wire [7:0] query_byte = stb_base | ({7'h00, mss} << isr_pkg::STB_RQS_BIT);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            resp_q     <= isr_pkg::BYTE_ZERO;
            resp_vld_q <= 1'b0;
        end else begin
            resp_vld_q <= i_serial_poll | i_stb_query;
            if (i_serial_poll) begin
                resp_q <= poll_byte;
            end else if (i_stb_query) begin
                resp_q <= query_byte;
            end
        end
    end

    assign o_stb_resp       = {8'h00, resp_q};
    assign o_stb_resp_valid = resp_vld_q;
    assign o_srq            = rqs_q;
    assign o_std_event      = {8'h00, std_event_q};
    assign o_std_enab       = {8'h00, std_enab_q};
    assign o_sre            = {8'h00, sre_q};

endmodule : isr_status_top
`default_nettype wire

// ---- isr_status_properties.sv ----
// Purpose: port-level checks of the status reporting block
// Assumes: single i_clk domain, asynchronous active-low reset
// Notes:   bound onto isr_status_top below
`timescale 1ns/100ps
`default_nettype none
module isr_status_properties #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    // watched inputs
    input wire logic [W-1:0]      i_oper_cond,
    input wire isr_pkg::isr_sev_s i_sev,
    input wire logic              i_trg_in_buffer,
    input wire logic              i_queue_nonempty,
    input wire logic              i_clear_status,
    input wire logic              i_rd_std_event,
    input wire logic              i_serial_poll,
    input wire logic              i_stb_query,
    // watched outputs
    input wire logic [W-1:0]      o_oper_event,
    input wire logic [W-1:0]      o_oper_cond,
    input wire logic [W-1:0]      o_oper_ptr,
    input wire logic [W-1:0]      o_oper_ntr,
    input wire logic [15:0]       o_std_event,
    input wire logic [15:0]       o_stb_resp,
    input wire logic              o_stb_resp_valid,
    input wire logic              o_srq
);
    // ************************************************************
    // checks
    // ************************************************************
    wire [7:0] sev_w = {2'b00, i_sev.cmd_err | i_trg_in_buffer, i_sev.exec_err,
                        i_sev.dev_err, i_sev.query_err, 1'b0, i_sev.opc_done};

    function automatic logic [W-1:0] hit(input logic [W-1:0] c, p, pt, nt);
        return (c ^ p) & ((c & pt) | (~c & nt));
    endfunction : hit

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_answer;
        ##1 o_stb_resp_valid;
    endsequence

    AST_ANSWER: assert property ((i_serial_poll || i_stb_query) |-> s_answer)
        else $error("status byte not answered");
    AST_NO_STRAY: assert property (
        o_stb_resp_valid |-> $past(i_serial_poll || i_stb_query))
        else $error("answer without request");
    AST_RSVD_ZERO: assert property (o_stb_resp_valid |-> o_stb_resp[1:0] == 2'b00)
        else $error("reserved bits set");
    AST_POLL_RQS: assert property (i_serial_poll |=> o_stb_resp[6] == $past(o_srq))
        else $error("poll bit 6 differs from service request");
    AST_QUEUE_BIT: assert property ($past(i_rst_n) && $past(i_queue_nonempty)
        && i_queue_nonempty && i_serial_poll |=> o_stb_resp[2])
        else $error("queue bit missing");
    AST_SEV_SET: assert property (
        sev_w != 8'h00 && !i_clear_status
        |=> (o_std_event[7:0] & $past(sev_w)) == $past(sev_w))
        else $error("standard event not latched");
    AST_STD_RDCLR: assert property (
        i_rd_std_event && sev_w == 8'h00 |=> o_std_event == 16'h0000)
        else $error("event read did not clear");
    AST_COND_LIVE: assert property ($past(i_rst_n, 1) && $past(i_rst_n, 2)
        && $past(i_rst_n, 3) |-> o_oper_cond == $past(i_oper_cond, 3))
        else $error("condition not live");
    AST_OPER_EDGE: assert property (
        $past(i_rst_n) && !$past(i_clear_status) |-> (hit(o_oper_cond, $past(o_oper_cond),
        $past(o_oper_ptr), $past(o_oper_ntr)) & ~o_oper_event) == '0)
        else $error("filtered transition lost");
    AST_OPER_NOSPUR: assert property ($past(i_rst_n) |-> (o_oper_event
        & ~$past(o_oper_event) & ~hit(o_oper_cond, $past(o_oper_cond), $past(o_oper_ptr),
        $past(o_oper_ntr))) == '0)
        else $error("event without filtered transition");
endmodule : isr_status_properties

bind isr_status_top isr_status_properties #(.W(W)) u_isr_chk (.i_clk, .i_rst_n, .i_oper_cond,
    .i_sev, .i_trg_in_buffer, .i_queue_nonempty, .i_clear_status, .i_rd_std_event,
    .i_serial_poll, .i_stb_query, .o_oper_event, .o_oper_cond, .o_oper_ptr, .o_oper_ntr,
    .o_std_event, .o_stb_resp, .o_stb_resp_valid, .o_srq);
`default_nettype wire

// ---- isr_ctrl_model.sv ----
// Purpose: remote controller model reading status
// Assumes: requests launched on the falling edge
// Notes:   one-cycle strobes, status byte answers taken one cycle later
`timescale 1ns/100ps
`default_nettype none
module isr_ctrl_model (
    // clock
    input  wire logic        i_clk,
    // answers
    input  wire logic [15:0] i_stb_resp,
    input  wire logic        i_stb_resp_valid,
    input  wire logic [15:0] i_std_event,
    // requests
    output logic             o_serial_poll,
    output logic             o_stb_query,
    output logic             o_rd_std_event
);
    // ************************************************************
    // status reads
    // ************************************************************
    initial begin
        o_serial_poll = 1'b0;
        o_stb_query = 1'b0;
        o_rd_std_event = 1'b0;
    end
    // either path may be used for the same byte
    task automatic read_stb(input logic qry, output logic [15:0] val, output logic ok);
        @(negedge i_clk);
        if (qry) o_stb_query = 1'b1;
        else o_serial_poll = 1'b1;
        @(negedge i_clk);
        o_serial_poll = 1'b0;
        o_stb_query = 1'b0;
        ok = i_stb_resp_valid;
        val = i_stb_resp;
    endtask : read_stb
    // event query: data stands before the clearing edge
    task automatic read_esr(output logic [15:0] val);
        @(negedge i_clk);
        o_rd_std_event = 1'b1;
        val = i_std_event;
        @(negedge i_clk);
        o_rd_std_event = 1'b0;
    endtask : read_esr
endmodule : isr_ctrl_model
`default_nettype wire

// ---- test_ieee488_status_reporting.sv ----
// Purpose: self-checking bench of the status block
// Assumes: 250 MHz clock, inputs driven on the falling edge
// Notes:   reference model held in plain variables
`timescale 1ns/100ps
`default_nettype none
module test_ieee488_status_reporting;
    // ************************************************************
    // signals and model state
    // ************************************************************
    logic        i_clk, i_rst_n, i_preset, i_clear_status, i_trg_in_buffer;
    logic        i_queue_nonempty, i_msg_ready, i_rd_oper_event, i_rd_ques_event;
    logic        i_rd_std_event, i_serial_poll, i_stb_query, o_stb_resp_valid, o_srq;
    logic [15:0] i_oper_cond, i_ques_cond, o_oper_event, o_oper_cond, o_ques_event;
    logic [15:0] o_ques_cond, o_oper_enab, o_oper_ptr, o_std_event, o_std_enab, o_stb_resp;
    logic [15:0] o_ques_enab, o_oper_ntr, o_ques_ptr, o_ques_ntr, o_sre;
    isr_pkg::isr_wr_s  i_wr;
    isr_pkg::isr_sev_s i_sev;
    int          err_count, checked, seed, t;
    int          bitpos [$];
    logic [15:0] oev, qev, oen, qen, en, ptr, ntr, nc, xp, rd;
    logic [7:0]  std_ev, ese, sre;
    logic        qn, mr, ok;

    isr_status_top i_isr_status_top (.i_clk, .i_rst_n, .i_oper_cond, .i_ques_cond, .i_wr,
        .i_preset, .i_clear_status, .i_sev, .i_trg_in_buffer, .i_queue_nonempty, .i_msg_ready,
        .i_rd_oper_event, .i_rd_ques_event, .i_rd_std_event, .i_serial_poll, .i_stb_query,
        .o_oper_event, .o_oper_cond, .o_ques_event, .o_ques_cond, .o_oper_enab, .o_ques_enab,
        .o_oper_ptr, .o_oper_ntr, .o_ques_ptr, .o_ques_ntr, .o_std_event, .o_std_enab,
        .o_sre, .o_stb_resp, .o_stb_resp_valid, .o_srq);
    isr_ctrl_model i_isr_ctrl_model (.i_clk, .i_stb_resp(o_stb_resp),
        .i_stb_resp_valid(o_stb_resp_valid), .i_std_event(o_std_event),
        .o_serial_poll(i_serial_poll), .o_stb_query(i_stb_query),
        .o_rd_std_event(i_rd_std_event));

    always #2 i_clk = ~i_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input isr_pkg::isr_sel_e s, input isr_pkg::isr_fld_e f,
                      input logic [15:0] d);
        @(negedge i_clk);
        i_wr = '{1'b1, s, f, d};
        @(negedge i_clk);
        i_wr.valid = 1'b0;
    endtask : wr

    // poll and query against the model; bit 6 never feeds the summary
    task automatic chk_stb;
        logic [15:0] e;
        e = 16'h0000;
        e[2] = qn;
        e[3] = |(qev & qen);
        e[4] = mr;
        e[5] = |(std_ev & ese);
        e[7] = |(oev & oen);
        e[6] = |(e[7:0] & sre & 8'hBF);
        repeat (3) @(negedge i_clk);
        i_isr_ctrl_model.read_stb(1'b1, rd, ok);
        chk(rd, e);
        chk({15'h0000, ok}, 16'h0001);
        i_isr_ctrl_model.read_stb(1'b0, rd, ok);
        chk(rd, e);
        chk({15'h0000, o_srq}, {15'h0000, e[6]});
    endtask : chk_stb

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        complete_run;
    end

    initial begin
        bitpos = '{isr_pkg::SEV_OPC_BIT, isr_pkg::SEV_QYE_BIT, isr_pkg::SEV_DDE_BIT,
                   isr_pkg::SEV_EXE_BIT, isr_pkg::SEV_CME_BIT, isr_pkg::SEV_CME_BIT};
        {i_clk, i_rst_n, i_preset, i_clear_status, i_trg_in_buffer} = '0;
        {i_queue_nonempty, i_msg_ready, i_rd_oper_event, i_rd_ques_event} = '0;
        {i_oper_cond, i_ques_cond, oev, qev, oen, qen, std_ev, ese, sre, qn, mr} = '0;
        i_wr = '0;
        i_sev = '0;
        seed = 59186;
        err_count = 0;
        checked = 0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        chk(o_oper_ptr, isr_pkg::PTR_RESET);
        i_isr_ctrl_model.read_esr(rd);
        chk(rd, 16'h0080);
        chk(o_std_event, 16'h0000);
        for (t = 0; t < 6; t++) begin
            ese = 8'($random(seed));
            sre = 8'($random(seed));
            wr(isr_pkg::ISR_SEL_STD, isr_pkg::ISR_FLD_ENAB, {8'h00, ese});
            wr(isr_pkg::ISR_SEL_SRE, isr_pkg::ISR_FLD_ENAB, {8'h00, sre});
            chk(o_std_enab, {8'h00, ese});
            // refused writes: wrong field on the standard register, no selector
            wr(isr_pkg::ISR_SEL_STD, isr_pkg::ISR_FLD_NTR, 16'hFFFF);
            wr(isr_pkg::ISR_SEL_NONE, isr_pkg::ISR_FLD_ENAB, 16'hFFFF);
            chk(o_std_enab, {8'h00, ese});
            chk(o_sre, {8'h00, sre});
            @(negedge i_clk);
            i_sev = isr_pkg::isr_sev_s'(5'b10000 >> t);
            i_trg_in_buffer = (t == 5);
            @(negedge i_clk);
            i_sev = '0;
            i_trg_in_buffer = 1'b0;
            std_ev = 8'(1 << bitpos[t]);
            chk(o_std_event, {8'h00, std_ev});
            chk_stb;
            i_isr_ctrl_model.read_esr(rd);
            chk(rd, {8'h00, std_ev});
            std_ev = 8'h00;
        end
        for (t = 0; t < 24; t++) begin
            ptr = 16'($random(seed)) & 16'h7FFF;
            ntr = (t % 5 == 4) ? ptr : 16'($random(seed)) & 16'h7FFF;
            if (t % 5 == 3) {ptr, ntr} = '0;
            en = 16'($random(seed)) & 16'h7FFF;
            wr(t[0] ? isr_pkg::ISR_SEL_QUES : isr_pkg::ISR_SEL_OPER, isr_pkg::ISR_FLD_PTR, ptr);
            wr(t[0] ? isr_pkg::ISR_SEL_QUES : isr_pkg::ISR_SEL_OPER, isr_pkg::ISR_FLD_NTR, ntr);
            wr(t[0] ? isr_pkg::ISR_SEL_QUES : isr_pkg::ISR_SEL_OPER, isr_pkg::ISR_FLD_ENAB, en);
            chk(t[0] ? o_ques_ptr : o_oper_ptr, ptr);
            chk(t[0] ? o_ques_ntr : o_oper_ntr, ntr);
            chk(t[0] ? o_ques_enab : o_oper_enab, en);
            qn = 1'($random(seed));
            mr = 1'($random(seed));
            @(negedge i_clk);
            i_queue_nonempty = qn;
            i_msg_ready = mr;
            if (t[0]) i_rd_ques_event = 1'b1;
            else i_rd_oper_event = 1'b1;
            @(negedge i_clk);
            {i_rd_oper_event, i_rd_ques_event} = '0;
            nc = 16'($random(seed));
            xp = t[0] ? i_ques_cond : i_oper_cond;
            xp = (nc ^ xp) & ((nc & ptr) | (~nc & ntr));
            if (t[0]) {i_ques_cond, qev, qen} = {nc, xp, en};
            else {i_oper_cond, oev, oen} = {nc, xp, en};
            repeat (5) @(negedge i_clk);
            chk(t[0] ? o_ques_event : o_oper_event, xp);
            chk(t[0] ? o_ques_cond : o_oper_cond, nc);
            chk_stb;
        end
        @(negedge i_clk);
        {i_preset, i_clear_status} = 2'b11;
        @(negedge i_clk);
        {i_preset, i_clear_status} = 2'b00;
        chk(o_oper_ptr | o_oper_enab, isr_pkg::PTR_RESET);
        chk(o_oper_event | o_std_event, 16'h0000);
        chk(o_ques_ptr, isr_pkg::PTR_RESET);
        chk(o_oper_ntr | o_ques_ntr | o_ques_enab | o_ques_event, 16'h0000);
        complete_run;
    end
endmodule : test_ieee488_status_reporting
`default_nettype wire
